// File: ucs_cfg.svh
`ifndef UCS_CFG_SVH
`define UCS_CFG_SVH
// Global status block byte offsets on odd addresses, 2 bytes apart.
`define UCS_OFF_GLOBAL_STATUS_CONTROL_1 5'h03
`define UCS_OFF_BOARD_IDENT 5'h05
`define UCS_OFF_SCR0 5'h07
`define UCS_OFF_SCR1 5'h09
`define UCS_OFF_SCR2 5'h0b
`define UCS_OFF_SCR3 5'h0d
`define UCS_OFF_SCR4 5'h0f
// Local-bus byte offsets of the utility registers.
`define UCS_OFF_UTILITY_CONTROL_STATUS 5'h10
`define UCS_OFF_SWITCH_BASE_ADDRESS 5'h14
`define UCS_OFF_GLOBAL_RESET_TRIGGER 5'h18
// Field positions.
`define UCS_G1_SYS_CTRL_SWITCH 6
`define UCS_G1_ISF 5
`define UCS_G1_FAIL 4
`define UCS_G1_HP 1
`define UCS_G1_LP 0
`define UCS_U_POWERUP_FLAG 14
`define UCS_U_DRIVE_FAIL 13
`define UCS_U_BRIRQ 12
`define UCS_U_ROBIN 11
`define UCS_U_LVL_HI 10
`define UCS_U_LVL_LO 9
`define UCS_U_NEVER 8
`define UCS_U_FAIR 7
`define UCS_U_RWD 6
`define UCS_U_GRANT_TIMEOUT_IRQ 5
`define UCS_U_VTO_HI 4
`define UCS_U_VTO_LO 3
`define UCS_U_EWD 2
`define UCS_U_WDA_HI 1
`define UCS_U_WDA_LO 0
// Reset values.
`define UCS_RST_SCR0 8'hff
`define UCS_RST_UTILITY_CONTROL_STATUS 15'h061b
// Timing.
`define UCS_CLK_MHZ 125
`define UCS_PULSE_MS 200
`define UCS_PULSE_CYC (`UCS_PULSE_MS * 1000 * `UCS_CLK_MHZ)
`define UCS_GRANT_S 1
`define UCS_GRANT_CYC (`UCS_GRANT_S * 1000000 * `UCS_CLK_MHZ)
`define UCS_VTO_US 32
`define UCS_VTO_CYC (`UCS_VTO_US * `UCS_CLK_MHZ)
`define UCS_SYSTEM_RESET_DLY_US 32
`define UCS_SYSTEM_RESET_DLY_CYC (`UCS_SYSTEM_RESET_DLY_US * `UCS_CLK_MHZ)
`endif

// File: ucs_pkg.sv
package ucs_pkg;
	typedef enum logic [1:0] {
		UCS_RS_IDLE = 2'b00,
		UCS_RS_WAIT = 2'b01,
		UCS_RS_PULSE = 2'b11
	} ucs_rst_e;
	typedef enum logic [1:0] {
		UCS_WD_SYS = 2'b00,
		UCS_WD_LOC = 2'b01,
		UCS_WD_HOLD = 2'b10,
		UCS_WD_OFF = 2'b11
	} ucs_wda_e;
endpackage

// File: ucs_regs.sv
`timescale 1ns/100ps
`include "ucs_cfg.svh"
// Function
// - Controller switch bit reads the switch, read-only, untouched by resets.
// - Inhibit bit blocks fail line; else fail line follows drive_fail; resets clear.
// - Board fail flag reads drive_fail or watchdog output, read-only.
// - Global status bits 3 and 2 read zero.
// - Signal bits: VMEbus write 1 sets, local write 0 clears; resets clear.
// - Board ident written only locally, read-only from VMEbus; resets clear.
// - Five scratch bytes; first loads FF on system reset, rest clear on both.
// - Powerup flag cleared by hardware on power-up and ACFAIL; software sets only.
// - drive_fail at 0 lights fail lamp regardless of inhibit; resets clear.
// - broadcast_irq drives IRQ1 low; line is open-collector; resets clear.
// - Round-robin when set, priority when clear; resets clear.
// - Request level 0-3 binary, resets load 11; no change while requesting.
// - never_release keeps the bus once acquired; resets clear.
// - fair_request withholds request while others request on the level; resets clear.
// - release_when_done releases at completion, else on request; resets clear.
// - Grant timeout withdraws grant after one second without BBSY, raises irq.
// - Strobe timeout 32/64/128 us as controller, 11 disables; resets load 11.
// - Watchdog acts on timer output low only when enabled; resets clear enable.
// - Watchdog actions: system pulse, local pulse, local hold, off; resets load 11.
// - Base address register mirrors switches, low nibble reads ones.
// - Any write to global reset starts 200 ms system reset; reads return ones.
// - System reset starts within 32 us; local reset meanwhile cancels it.
module ucs_regs
	import ucs_pkg::*;
#(
	parameter int unsigned PULSE_CYC = `UCS_PULSE_CYC,
	parameter int unsigned GRANT_CYC = `UCS_GRANT_CYC
) (
	input wire logic core_clk, // Board clock.
	input wire logic resetn, // Synchronous reset, active low.
	input wire logic power_up, // Power-on indication, active high.
	input wire logic sys_reset_in, // System reset level from the backplane.
	input wire logic loc_reset_in, // Local reset level.
	input wire logic acfail_n, // ACFAIL line, active low.
	input wire logic sys_ctrl_switch_sw, // Controller switch, 1 = on.
	input wire logic [11:0] addr_sw, // Base address switches.
	input wire logic [15:0] vme_addr, // VMEbus A16 address.
	input wire logic vme_sel, // VMEbus byte access strobe to A16 space.
	input wire logic vme_wr, // VMEbus access is a write.
	input wire logic [7:0] vme_wdata, // VMEbus write data.
	input wire logic loc_sel, // Local bus access strobe.
	input wire logic loc_wr, // Local bus access is a write.
	input wire logic [4:0] loc_addr, // Local bus byte offset.
	input wire logic [31:0] loc_wdata, // Local bus write data.
	input wire logic ds_n, // Either VMEbus data strobe, active low.
	input wire logic grant_out, // Arbiter is asserting a bus grant.
	input wire logic bbsy_n, // BBSY line, active low.
	input wire logic timer3_out, // Counter timer three output.
	output logic [7:0] vme_rdata, // VMEbus read data.
	output logic vme_ack, // VMEbus access acknowledge.
	output logic [31:0] loc_rdata, // Local bus read data.
	output logic loc_ack, // Local bus access acknowledge.
	output logic sysfail_oe_n, // SYSFAIL drive enable, low drives.
	output logic fail_led, // Front-panel fail lamp.
	output logic irq1_oe_n, // IRQ1 drive enable, low drives.
	output logic hp_irq, // High priority signal pending.
	output logic lp_irq, // Low priority signal pending.
	output logic [14:0] utility_control_status_out, // Utility control fields to arbiter and requester.
	output logic grant_withdraw, // Arbiter drops the grant.
	output logic grant_timeout_irq, // Grant timeout interrupt request pulse.
	output logic berr_out, // Assert BERR for transfer timeout.
	output logic sys_reset_out, // System reset drive.
	output logic loc_reset_out // Local reset drive.
);
	// Synchronisers for pins.
	logic [1:0] s1_q, s2_q;
	logic [11:0] sw1_q, sw2_q;
	logic [4:0] p1_q, p2_q;
	always_ff @(posedge core_clk) begin
		s1_q <= {sys_ctrl_switch_sw, timer3_out};
		s2_q <= s1_q;
		sw1_q <= addr_sw;
		sw2_q <= sw1_q;
		p1_q <= {power_up, acfail_n, ds_n, bbsy_n, 1'b0};
		p2_q <= p1_q;
	end
	wire sys_ctrl_switch = s2_q[1];
	wire t3 = s2_q[0];
	wire pwr = p2_q[4];
	wire acf_n = p2_q[3];
	wire dsn = p2_q[2];
	wire bbn = p2_q[1];
	logic [1:0] r1_q, r2_q;
	always_ff @(posedge core_clk) begin
		r1_q <= {sys_reset_in, loc_reset_in};
		r2_q <= r1_q;
	end
	wire system_reset = r2_q[1] | sys_reset_out;
	wire local_reset = r2_q[0] | loc_reset_out;
	wire any_rst = !resetn | system_reset | local_reset;

	logic isf_q, hp_q, lp_q, pwr_q;
	logic [7:0] id_q;
	logic [7:0] scr_q [5];
	logic [14:0] u_q;
	wire drive_fail = ~u_q[`UCS_U_DRIVE_FAIL];
	wire [1:0] wda = u_q[`UCS_U_WDA_HI:`UCS_U_WDA_LO];
	wire [1:0] vto = u_q[`UCS_U_VTO_HI:`UCS_U_VTO_LO];
	wire wd_fire = u_q[`UCS_U_EWD] && !t3 && wda != UCS_WD_OFF;

	// VMEbus decode against switches.
	wire vme_hit = vme_sel && vme_addr[15:4] == sw2_q;
	wire [3:0] vo = vme_addr[3:0];
	wire vw = vme_hit && vme_wr;
	wire lw = loc_sel && loc_wr;
	wire [4:0] la = loc_addr;
	wire vw_g1 = vw && {1'b0, vo} == `UCS_OFF_GLOBAL_STATUS_CONTROL_1;
	wire lw_g1 = lw && la == `UCS_OFF_GLOBAL_STATUS_CONTROL_1;
	wire lw_id = lw && la == `UCS_OFF_BOARD_IDENT;
	wire lw_u = lw && la == `UCS_OFF_UTILITY_CONTROL_STATUS;
	wire lw_gr = lw && la == `UCS_OFF_GLOBAL_RESET_TRIGGER;

	function automatic logic [4:0] scr_off(input int i);
		scr_off = 5'(`UCS_OFF_SCR0 + 2 * i);
	endfunction

	wire fail_flag = drive_fail | wd_fire;
	wire [7:0] g1 = {1'b0, sys_ctrl_switch, isf_q, fail_flag, 2'b00, hp_q, lp_q};
	wire [15:0] switch_base_address = {sw2_q, 4'hf};
	wire [15:0] utility_control_status_rd = {1'b0, pwr_q, u_q[13:0]};

	function automatic logic [7:0] gsb_rd(input logic [4:0] a);
		gsb_rd = 8'h00;
		if (a == `UCS_OFF_GLOBAL_STATUS_CONTROL_1) begin
			gsb_rd = g1;
		end else if (a == `UCS_OFF_BOARD_IDENT) begin
			gsb_rd = id_q;
		end else begin
			for (int i = 0; i < 5; i++) begin
				if (a == scr_off(i)) begin
					gsb_rd = scr_q[i];
				end
			end
		end
	endfunction

	always_ff @(posedge core_clk) begin
		if (any_rst) begin
			isf_q <= 1'b0;
			hp_q <= 1'b0;
			lp_q <= 1'b0;
			id_q <= 8'h00;
			u_q <= `UCS_RST_UTILITY_CONTROL_STATUS;
			u_q[`UCS_U_POWERUP_FLAG] <= 1'b0;
		end else begin
			if (vw_g1 || lw_g1) begin
				isf_q <= vw_g1 ? vme_wdata[`UCS_G1_ISF] : loc_wdata[`UCS_G1_ISF];
			end
			if (vw_g1 && vme_wdata[`UCS_G1_HP]) begin
				hp_q <= 1'b1;
			end else if (lw_g1 && !loc_wdata[`UCS_G1_HP]) begin
				hp_q <= 1'b0;
			end
			if (vw_g1 && vme_wdata[`UCS_G1_LP]) begin
				lp_q <= 1'b1;
			end else if (lw_g1 && !loc_wdata[`UCS_G1_LP]) begin
				lp_q <= 1'b0;
			end
			if (lw_id) begin
				id_q <= loc_wdata[7:0];
			end
			if (lw_u) begin
				u_q <= loc_wdata[14:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		for (int i = 0; i < 5; i++) begin
			if (!resetn || system_reset || (local_reset && i != 0)) begin
				scr_q[i] <= (i == 0) ? `UCS_RST_SCR0 : 8'h00;
			end else if (vw && {1'b0, vo} == scr_off(i)) begin
				scr_q[i] <= vme_wdata;
			end else if (lw && la == scr_off(i)) begin
				scr_q[i] <= loc_wdata[7:0];
			end
		end
	end

	// Power-up flag: hardware clear wins over software set.
	always_ff @(posedge core_clk) begin
		if (!resetn || pwr || !acf_n) begin
			pwr_q <= 1'b0;
		end else if (lw_u && loc_wdata[`UCS_U_POWERUP_FLAG]) begin
			pwr_q <= 1'b1;
		end
	end

	// Grant timeout.
	logic [27:0] gcnt_q;
	always_ff @(posedge core_clk) begin
		if (any_rst || !grant_out || !bbn || !u_q[`UCS_U_GRANT_TIMEOUT_IRQ]) begin
			gcnt_q <= '0;
			grant_withdraw <= 1'b0;
			grant_timeout_irq <= 1'b0;
		end else if (gcnt_q == 28'(GRANT_CYC - 1)) begin
			grant_withdraw <= 1'b1;
			grant_timeout_irq <= !grant_withdraw;
		end else begin
			gcnt_q <= gcnt_q + 28'h1;
		end
	end

	// Transfer timeout, length 32 us shifted by the select code.
	logic [15:0] vcnt_q;
	wire [15:0] vlim = 16'(`UCS_VTO_CYC) << vto;
	always_ff @(posedge core_clk) begin
		if (any_rst || dsn || !sys_ctrl_switch || vto == 2'b11) begin
			vcnt_q <= '0;
			berr_out <= 1'b0;
		end else if (vcnt_q == vlim - 16'h1) begin
			berr_out <= 1'b1;
		end else begin
			vcnt_q <= vcnt_q + 16'h1;
		end
	end

	// Reset generator for global reset and watchdog.
	ucs_rst_e rs_q;
	logic [24:0] rcnt_q;
	logic sys_sel_q, hold_q;
	wire wd_sys = wd_fire && wda == UCS_WD_SYS;
	wire wd_loc = wd_fire && wda == UCS_WD_LOC;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rs_q <= UCS_RS_IDLE;
			rcnt_q <= '0;
			sys_sel_q <= 1'b0;
			sys_reset_out <= 1'b0;
			loc_reset_out <= 1'b0;
		end else begin
			case (rs_q)
			UCS_RS_IDLE: begin
				rcnt_q <= '0;
				if (lw_gr || wd_sys) begin
					rs_q <= UCS_RS_WAIT;
					sys_sel_q <= 1'b1;
				end else if (wd_loc) begin
					rs_q <= UCS_RS_PULSE;
					sys_sel_q <= 1'b0;
					loc_reset_out <= 1'b1;
				end
			end
			UCS_RS_WAIT: begin
				rcnt_q <= rcnt_q + 25'h1;
				if (r2_q[0]) begin
					rs_q <= UCS_RS_IDLE;
				end else if (rcnt_q == 25'(`UCS_SYSTEM_RESET_DLY_CYC - 1)) begin
					rs_q <= UCS_RS_PULSE;
					rcnt_q <= '0;
					sys_reset_out <= 1'b1;
				end
			end
			UCS_RS_PULSE: begin
				rcnt_q <= rcnt_q + 25'h1;
				if (rcnt_q == 25'(PULSE_CYC - 1)) begin
					rs_q <= UCS_RS_IDLE;
					sys_reset_out <= 1'b0;
					loc_reset_out <= 1'b0;
				end
			end
			default: rs_q <= UCS_RS_IDLE;
			endcase
			if (hold_q) begin
				loc_reset_out <= 1'b1;
			end
		end
	end
	always_ff @(posedge core_clk) begin
		hold_q <= resetn && (hold_q || (wd_fire && wda == UCS_WD_HOLD));
	end

	// Bus answers and pin outputs.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			vme_rdata <= 8'h00;
			vme_ack <= 1'b0;
			loc_rdata <= 32'h0;
			loc_ack <= 1'b0;
			sysfail_oe_n <= 1'b1;
			fail_led <= 1'b0;
			irq1_oe_n <= 1'b1;
			hp_irq <= 1'b0;
			lp_irq <= 1'b0;
			utility_control_status_out <= `UCS_RST_UTILITY_CONTROL_STATUS;
		end else begin
			vme_ack <= vme_hit && vo[0];
			vme_rdata <= gsb_rd({1'b0, vo});
			loc_ack <= loc_sel;
			if (la == `UCS_OFF_UTILITY_CONTROL_STATUS) begin
				loc_rdata <= {16'h0, utility_control_status_rd};
			end else if (la == `UCS_OFF_SWITCH_BASE_ADDRESS) begin
				loc_rdata <= {16'h0, switch_base_address};
			end else if (la == `UCS_OFF_GLOBAL_RESET_TRIGGER) begin
				loc_rdata <= 32'hffffffff;
			end else begin
				loc_rdata <= {24'h0, gsb_rd(la)};
			end
			sysfail_oe_n <= !(drive_fail && !isf_q);
			fail_led <= fail_flag;
			irq1_oe_n <= !u_q[`UCS_U_BRIRQ];
			hp_irq <= hp_q;
			lp_irq <= lp_q;
			utility_control_status_out <= {pwr_q, u_q[13:0]};
		end
	end
endmodule // ucs_regs

// File: ucs_regs_props.sv
`timescale 1ns/100ps
module ucs_regs_props #(
	parameter int unsigned PULSE_CYC = 50
) (
	input wire logic core_clk, // Board clock.
	input wire logic resetn, // Synchronous reset, active low.
	input wire logic acfail_n, // ACFAIL line, active low.
	input wire logic vme_sel, // VMEbus strobe.
	input wire logic vme_ack, // VMEbus acknowledge.
	input wire logic loc_ack, // Local acknowledge.
	input wire logic sysfail_oe_n, // SYSFAIL drive enable.
	input wire logic fail_led, // Fail lamp.
	input wire logic irq1_oe_n, // IRQ1 drive enable.
	input wire logic hp_irq, // High priority pending.
	input wire logic [14:0] utility_control_status_out, // Utility fields.
	input wire logic grant_timeout_irq, // Grant timeout pulse.
	input wire logic berr_out, // Transfer timeout.
	input wire logic sys_reset_out // System reset drive.
);
	logic [31:0] run_q; // Cycles the system reset has been driven so far.
	always_ff @(posedge core_clk) begin
		run_q <= sys_reset_out ? run_q + 32'h1 : 32'h0;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	vme_ack_cause_a: assert property (vme_ack |-> $past(vme_sel))
		else $error("vme ack without a request");
	reset_values_a: assert property ($past(!resetn) |-> utility_control_status_out[13:0] == 14'h061b)
		else $error("utility fields wrong after reset");
	sysfail_lamp_a: assert property (!sysfail_oe_n |-> fail_led)
		else $error("fail line driven with lamp dark");
	lamp_follow_a: assert property (!utility_control_status_out[13] [*2] |-> fail_led)
		else $error("lamp dark while fail asserted");
	irq_release_a: assert property (!utility_control_status_out[12] [*2] |-> irq1_oe_n)
		else $error("irq line driven while broadcast clear");
	pulse_width_a: assert property ($fell(sys_reset_out) |-> run_q == PULSE_CYC)
		else $error("system reset pulse has wrong length");
	grant_pulse_a: assert property (grant_timeout_irq |=> !grant_timeout_irq)
		else $error("grant timeout request longer than a cycle");
	berr_off_a: assert property (berr_out |-> utility_control_status_out[4:3] != 2'b11)
		else $error("bus error while timer disabled");
	hp_from_vme_a: assert property ($rose(hp_irq) |-> $past(vme_ack))
		else $error("high priority set without vme write");
	acfail_clear_a: assert property (!acfail_n [*4] |=> !utility_control_status_out[14])
		else $error("powerup flag not cleared by acfail");
	pwr_set_a: assert property ($rose(utility_control_status_out[14]) |-> loc_ack || $past(loc_ack))
		else $error("powerup flag set without local write");
	cover property ($rose(sys_reset_out));
	cover property (!irq1_oe_n);
	cover property (grant_timeout_irq);
	cover property (berr_out);
endmodule // ucs_regs_props

// File: ucs_bus_agent.sv
`timescale 1ns/100ps
module ucs_bus_agent (
	input wire logic core_clk, // Board clock.
	input wire logic [7:0] vme_rdata, // VMEbus read data.
	input wire logic vme_ack, // VMEbus acknowledge.
	input wire logic [31:0] loc_rdata, // Local read data.
	input wire logic loc_ack, // Local acknowledge.
	output logic [15:0] vme_addr, // VMEbus address.
	output logic vme_sel, // VMEbus strobe.
	output logic vme_wr, // VMEbus write.
	output logic [7:0] vme_wdata, // VMEbus write data.
	output logic loc_sel, // Local strobe.
	output logic loc_wr, // Local write.
	output logic [4:0] loc_addr, // Local offset.
	output logic [31:0] loc_wdata // Local write data.
);
	initial begin
		{vme_addr, vme_sel, vme_wr, vme_wdata} = 26'h0;
		{loc_sel, loc_wr, loc_addr, loc_wdata} = 39'h0;
	end
	// The request is held until the acknowledge is sampled high, or a few cycles pass.
	// Released address and data lines show the inverse so stale values are never mistaken for live ones.
	task automatic vme(input logic wr, input logic [15:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		rd = 8'h00;
		@(posedge core_clk);
		{vme_sel, vme_wr, vme_addr, vme_wdata} <= {1'b1, wr, a, d};
		while (!ok && n < 4) begin
			@(posedge core_clk);
			ok = vme_ack;
			rd = vme_rdata;
			n++;
		end
		{vme_sel, vme_addr, vme_wdata} <= {1'b0, ~a, ~d};
	endtask
	task automatic loc(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		rd = 32'h0;
		@(posedge core_clk);
		{loc_sel, loc_wr, loc_addr, loc_wdata} <= {1'b1, wr, a, d};
		while (!ok && n < 4) begin
			@(posedge core_clk);
			ok = loc_ack;
			rd = loc_rdata;
			n++;
		end
		{loc_sel, loc_addr, loc_wdata} <= {1'b0, ~a, ~d};
	endtask
endmodule // ucs_bus_agent

// File: ucs_regs_bench.sv
`timescale 1ns/100ps
module ucs_regs_bench;
	localparam int unsigned PULSE = 50;
	localparam logic [11:0] BASE = 12'ha5c;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic power_up = 1'b1;
	logic sys_reset_in = 1'b0;
	logic loc_reset_in = 1'b0;
	logic acfail_n = 1'b1;
	logic sys_ctrl_switch_sw = 1'b1;
	logic ds_n = 1'b1;
	logic grant_out = 1'b0;
	logic bbsy_n = 1'b1;
	logic timer3_out = 1'b1;
	logic [15:0] vme_addr;
	logic [7:0] vme_wdata, vme_rdata, rd8, b;
	logic [4:0] loc_addr;
	logic [31:0] loc_wdata, loc_rdata, rd32;
	logic [14:0] utility_control_status_out;
	logic vme_sel, vme_wr, loc_sel, loc_wr, vme_ack, loc_ack, sysfail_oe_n, fail_led, irq1_oe_n;
	logic hp_irq, lp_irq, grant_withdraw, berr_out, sys_reset_out, loc_reset_out, ok;
	logic grant_timeout_irq;
	logic gto_seen = 1'b0;
	int n_errors = 0;
	int compares = 0;
	int seed = 83;
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (grant_timeout_irq) gto_seen <= 1'b1;
	end
	ucs_regs #(.PULSE_CYC(PULSE), .GRANT_CYC(100)) ucs_regs_inst (.core_clk, .resetn, .power_up,
		.sys_reset_in, .loc_reset_in, .acfail_n, .sys_ctrl_switch_sw, .addr_sw(BASE), .vme_addr, .vme_sel,
		.vme_wr, .vme_wdata, .loc_sel, .loc_wr, .loc_addr, .loc_wdata, .ds_n, .grant_out, .bbsy_n,
		.timer3_out, .vme_rdata, .vme_ack, .loc_rdata, .loc_ack, .sysfail_oe_n, .fail_led,
		.irq1_oe_n, .hp_irq, .lp_irq, .utility_control_status_out, .grant_withdraw, .grant_timeout_irq,
		.berr_out, .sys_reset_out, .loc_reset_out);
	ucs_bus_agent agent_inst (.core_clk, .vme_rdata, .vme_ack, .loc_rdata, .loc_ack, .vme_addr, .vme_sel,
		.vme_wr, .vme_wdata, .loc_sel, .loc_wr, .loc_addr, .loc_wdata);
	function automatic logic [7:0] g1(logic inhibit_sysfail, logic fl, logic hp, logic lp);
		return {1'b0, sys_ctrl_switch_sw, inhibit_sysfail, fl, 2'b00, hp, lp};
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic vw(input logic [3:0] o, input logic [7:0] d);
		agent_inst.vme(1'b1, {BASE, o}, d, rd8, ok);
	endtask
	task automatic vr(input logic [3:0] o, input logic [7:0] e);
		agent_inst.vme(1'b0, {BASE, o}, 8'h00, rd8, ok);
		chk("vme read", {23'h0, ok, rd8}, {23'h0, 1'b1, e});
	endtask
	task automatic lw(input logic [4:0] a, input logic [31:0] d);
		agent_inst.loc(1'b1, a, d, rd32);
	endtask
	task automatic lr(input logic [4:0] a, input logic [31:0] e);
		agent_inst.loc(1'b0, a, 32'h0, rd32);
		chk("local read", rd32, e);
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		power_up <= 1'b0;
		repeat (4) @(posedge core_clk);
		lr(5'h10, 32'h061b);
		lr(5'h14, {16'h0, BASE, 4'hf});
		lr(5'h18, 32'hffffffff);
		vr(4'h3, g1(0, 1, 0, 0));
		vr(4'h7, 8'hff);
		chk("sysfail", sysfail_oe_n, 1'b0);
		agent_inst.vme(1'b0, {~BASE, 4'h7}, 8'h00, rd8, ok);
		chk("foreign ack", ok, 1'b0);
		$display("test reset values done");
		vw(4'h3, 8'h03);
		vr(4'h3, g1(0, 1, 1, 1));
		chk("signals", {hp_irq, lp_irq}, 2'b11);
		lw(5'h03, 32'h0);
		vr(4'h3, g1(0, 1, 0, 0));
		vw(4'h5, 8'h5a);
		vr(4'h5, 8'h00);
		lw(5'h05, {4{8'h3c}});
		vr(4'h5, 8'h3c);
		for (int i = 0; i < 5; i++) begin
			b = $random(seed);
			if ($random(seed) & 1) vw(4'h7 + 4'(2 * i), b);
			else lw(5'h07 + 5'(2 * i), {4{b}});
			vr(4'h7 + 4'(2 * i), b);
		end
		$display("test global_status_block done");
		vw(4'h3, 8'h20);
		repeat (3) @(posedge core_clk);
		chk("inhibit", {sysfail_oe_n, fail_led}, 2'b11);
		lw(5'h10, 32'h7aa3);
		lr(5'h10, 32'h7aa3);
		vr(4'h3, g1(1, 0, 0, 0));
		chk("irq1", {irq1_oe_n, fail_led}, 2'b00);
		acfail_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		acfail_n <= 1'b1;
		lr(5'h10, 32'h3aa3);
		ds_n <= 1'b0;
		repeat (3990) @(posedge core_clk);
		chk("berr early", berr_out, 1'b0);
		repeat (20) @(posedge core_clk);
		chk("berr", berr_out, 1'b1);
		ds_n <= 1'b1;
		grant_out <= 1'b1;
		repeat (95) @(posedge core_clk);
		chk("withdraw early", grant_withdraw, 1'b0);
		repeat (15) @(posedge core_clk);
		chk("withdraw", grant_withdraw, 1'b1);
		chk("grant irq", gto_seen, 1'b1);
		grant_out <= 1'b0;
		$display("test utility done");
		lw(5'h10, 32'h0005);
		timer3_out <= 1'b0;
		repeat (6) @(posedge core_clk);
		chk("watchdog", loc_reset_out, 1'b1);
		timer3_out <= 1'b1;
		repeat (PULSE + 20) @(posedge core_clk);
		chk("watchdog end", loc_reset_out, 1'b0);
		lr(5'h10, 32'h061b);
		vr(4'hf, 8'h00);
		lw(5'h18, $random(seed));
		repeat (100) @(posedge core_clk);
		loc_reset_in <= 1'b1;
		repeat (4) @(posedge core_clk);
		loc_reset_in <= 1'b0;
		repeat (4100) @(posedge core_clk);
		chk("cancelled", sys_reset_out, 1'b0);
		lw(5'h18, $random(seed));
		repeat (4010) @(posedge core_clk);
		chk("global reset", sys_reset_out, 1'b1);
		repeat (PULSE + 10) @(posedge core_clk);
		chk("global end", sys_reset_out, 1'b0);
		vr(4'h7, 8'hff);
		$display("test resets done");
		final_report();
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		n_errors++;
		final_report();
	end
endmodule // ucs_regs_bench
bind ucs_regs ucs_regs_props #(.PULSE_CYC(PULSE_CYC)) props_inst (.core_clk, .resetn, .acfail_n,
	.vme_sel, .vme_ack, .loc_ack, .sysfail_oe_n, .fail_led, .irq1_oe_n, .hp_irq, .utility_control_status_out,
	.grant_timeout_irq, .berr_out, .sys_reset_out);
